// File: design/rbh_map.vh
// register offsets, field positions, reset values and timing counts
`ifndef RBH_MAP_VH
`define RBH_MAP_VH
`define RBH_ADR_STAT0 4'h0
`define RBH_ADR_STAT1 4'h1
`define RBH_ADR_SYSTEM_ERROR_WORD 4'h2
`define RBH_ADR_IRQ_STAT 4'h3
`define RBH_ADR_IRQ_MASK 4'h4
`define RBH_ADR_CTRL 4'h5
`define RBH_ADR_DATA0 4'h8
`define RBH_ADR_DATA1 4'hC
`define RBH_CNT_LO 3
`define RBH_ERR_LO 4
`define RBH_SFRM_BIT 6
`define RBH_EFRM_BIT 7
`define RBH_SYSTEM_ERROR_WORD_RX_BIT 0
`define RBH_IRQ_FULL_BIT 0
`define RBH_IRQ_ERR_BIT 1
`define RBH_CTRL_HDLC_BIT 0
`define RBH_CTRL_FSK_BIT 1
`define RBH_CTRL_RATE_LO 2
`define RBH_STAT_RST 8'h00
`define RBH_MASK_RST 2'h0
`define RBH_CTRL_RST 4'h0
`define RBH_CLK_HZ 200000000
`define RBH_BAUD_1200 1200
`define RBH_BAUD_300 300
`define RBH_BAUD_75 75
`define RBH_DIV_1200 (`RBH_CLK_HZ / `RBH_BAUD_1200)
`define RBH_DIV_300 (`RBH_CLK_HZ / `RBH_BAUD_300)
`define RBH_DIV_75 (`RBH_CLK_HZ / `RBH_BAUD_75)
`define RBH_BUF_BYTES 8
`endif

// File: design/rbh_rx_buffer.v
// receive buffer pair with status handshake and wishbone slave
`timescale 1ns/1ps
`include "rbh_map.vh"

// What this block does
// - device sets status, host alone clears it
// - improper host clear flags receive error bit
// - zero status means buffer free for filling
// - fsk mode samples one bit per baud
// - bits 3:0 hold valid byte count 1-8
// - synchronous mode reports byte count only
// - hdlc mode adds error code, start, end marks
// - on buffer full write status, raise interrupt
// - freeness checked just before filling starts
module rbh_rx_buffer #(
    parameter DIV_1200 = `RBH_DIV_1200,
    parameter DIV_300 = `RBH_DIV_300,
    parameter DIV_75 = `RBH_DIV_75
) (
    input wire i_clk,
    input wire i_rst_n,
    input wire i_wb_cyc,
    input wire i_wb_stb,
    input wire i_wb_we,
    input wire [3:0] i_wb_adr,
    input wire [3:0] i_wb_sel,
    input wire [31:0] i_wb_dat,
    output reg [31:0] o_wb_dat,
    output reg o_wb_ack,
    input wire i_rx_valid,
    input wire [7:0] i_rx_byte,
    input wire i_rx_bit,
    input wire i_rx_frame_start,
    input wire i_rx_frame_end,
    input wire [1:0] i_rx_err,
    output reg o_rx_ready,
    output reg o_irq
);

    // ********************************
    // registers
    // ********************************
    reg [7:0] stat_reg [0:1];
    reg [7:0] mem_reg [0:15];
    reg sys_err_reg;
    reg [1:0] irq_stat_reg;
    reg [1:0] irq_mask_reg;
    reg [3:0] ctrl_reg;
    reg fill_sel_reg;
    reg filling_reg;
    reg [3:0] cnt_reg;
    reg sfrm_reg;
    reg [31:0] baud_reg;
    reg [2:0] bitpos_reg;
    reg [7:0] shift_reg;
    reg host_sel_reg;

    wire hdlc = ctrl_reg[`RBH_CTRL_HDLC_BIT];
    wire fsk = ctrl_reg[`RBH_CTRL_FSK_BIT];
    wire [1:0] rate = ctrl_reg[`RBH_CTRL_RATE_LO+1:`RBH_CTRL_RATE_LO];
    wire wb_req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
    wire wb_wr = wb_req & i_wb_we & i_wb_sel[0];

    // ********************************
    // fsk bit sampler
    // ********************************
    reg [31:0] baud_div;
    always @* begin
        case (rate)
            2'h0: baud_div = DIV_1200;
            2'h1: baud_div = DIV_300;
            default: baud_div = DIV_75;
        endcase
    end

    wire baud_tick = (baud_reg >= baud_div - 32'h1);
    reg fsk_byte_valid;
    reg [7:0] fsk_byte;
    always @* begin
        fsk_byte_valid = fsk & baud_tick & (bitpos_reg == 3'h7);
        fsk_byte = {i_rx_bit, shift_reg[7:1]};
    end

    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            baud_reg <= 32'h0;
            bitpos_reg <= 3'h0;
            shift_reg <= 8'h00;
        end else if (!fsk) begin
            baud_reg <= 32'h0;
            bitpos_reg <= 3'h0;
        end else if (baud_tick) begin
            baud_reg <= 32'h0;
            shift_reg <= {i_rx_bit, shift_reg[7:1]};
            bitpos_reg <= bitpos_reg + 3'h1;
        end else begin
            baud_reg <= baud_reg + 32'h1;
        end
    end

    // ********************************
    // receive input select
    // ********************************
    wire in_valid = fsk ? fsk_byte_valid : i_rx_valid;
    wire [7:0] in_byte = fsk ? fsk_byte : i_rx_byte;

    // ********************************
    // deframer side fill
    // ********************************
    wire cur_free = (stat_reg[fill_sel_reg] == `RBH_STAT_RST);
    wire other_free = (stat_reg[~fill_sel_reg] == `RBH_STAT_RST);
    wire can_take = filling_reg | cur_free;
    wire take_now = in_valid & can_take;
    wire last_byte = (cnt_reg == 4'h7);
    wire frame_close = hdlc & (i_rx_frame_end | (i_rx_err != 2'h0));
    wire close_now = take_now & (last_byte | frame_close);
    wire [3:0] cnt_inc = cnt_reg + 4'h1;
    wire [3:0] wr_idx = {fill_sel_reg, cnt_reg[2:0]};

    // ********************************
    // status word build
    // ********************************
    reg [7:0] new_stat;
    always @* begin
        new_stat = `RBH_STAT_RST;
        new_stat[`RBH_CNT_LO:0] = cnt_inc;
        if (hdlc) begin
            new_stat[`RBH_ERR_LO+1:`RBH_ERR_LO] = i_rx_err;
            new_stat[`RBH_SFRM_BIT] = sfrm_reg | (~filling_reg & i_rx_frame_start);
            new_stat[`RBH_EFRM_BIT] = i_rx_frame_end;
        end else begin
            new_stat[7:4] = 4'h0;
        end
    end

    // ********************************
    // register write decode
    // ********************************
    wire w_stat0 = wb_wr & (i_wb_adr == `RBH_ADR_STAT0);
    wire w_stat1 = wb_wr & (i_wb_adr == `RBH_ADR_STAT1);
    wire w_system_error_word = wb_wr & (i_wb_adr == `RBH_ADR_SYSTEM_ERROR_WORD);
    wire w_istat = wb_wr & (i_wb_adr == `RBH_ADR_IRQ_STAT);
    wire w_imask = wb_wr & (i_wb_adr == `RBH_ADR_IRQ_MASK);
    wire w_ctrl = wb_wr & (i_wb_adr == `RBH_ADR_CTRL);

    // ********************************
    // host release check
    // ********************************
    wire clr_any = w_stat0 | w_stat1;
    wire clr_idx = w_stat1;
    wire clr_nonzero = (i_wb_dat[7:0] != 8'h00);
    wire clr_empty = (stat_reg[clr_idx] == `RBH_STAT_RST);
    wire clr_order = (clr_idx != host_sel_reg);
    // improper: nonzero value, empty buffer, or out of order
    wire bad_clr = clr_any & (clr_nonzero | clr_empty | clr_order);
    wire good_clr = clr_any & ~bad_clr;

    // ********************************
    // status words
    // ********************************
    wire [15:0] stat_next;
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_stat
            wire set_g = close_now & (fill_sel_reg == g);
            wire clr_g = good_clr & (clr_idx == g);
            assign stat_next[8*g+7:8*g] = set_g ? new_stat :
                (clr_g ? `RBH_STAT_RST : stat_reg[g]);
        end
    endgenerate

    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            stat_reg[0] <= `RBH_STAT_RST;
            stat_reg[1] <= `RBH_STAT_RST;
        end else begin
            stat_reg[0] <= stat_next[7:0];
            stat_reg[1] <= stat_next[15:8];
        end
    end

    // ********************************
    // buffer memory
    // ********************************
    always @(posedge i_clk) begin
        if (take_now) begin
            mem_reg[wr_idx] <= in_byte;
        end
    end

    // ********************************
    // fill control
    // ********************************
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            fill_sel_reg <= 1'b0;
            filling_reg <= 1'b0;
            cnt_reg <= 4'h0;
            sfrm_reg <= 1'b0;
        end else if (close_now) begin
            fill_sel_reg <= ~fill_sel_reg;
            filling_reg <= 1'b0;
            cnt_reg <= 4'h0;
            sfrm_reg <= 1'b0;
        end else if (take_now) begin
            filling_reg <= 1'b1;
            cnt_reg <= cnt_inc;
            if (!filling_reg) begin
                sfrm_reg <= i_rx_frame_start;
            end
        end
    end

    // ********************************
    // host release order
    // ********************************
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            host_sel_reg <= 1'b0;
        end else if (good_clr) begin
            host_sel_reg <= ~host_sel_reg;
        end
    end

    // ********************************
    // ready output
    // ********************************
    // follows the buffer the next byte lands in
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rx_ready <= 1'b0;
        end else if (close_now) begin
            o_rx_ready <= other_free;
        end else begin
            o_rx_ready <= cur_free | filling_reg;
        end
    end

    // ********************************
    // system error word
    // ********************************
    wire system_error_word_clr = w_system_error_word & i_wb_dat[`RBH_SYSTEM_ERROR_WORD_RX_BIT];
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sys_err_reg <= 1'b0;
        end else if (bad_clr) begin
            sys_err_reg <= 1'b1;
        end else if (system_error_word_clr) begin
            sys_err_reg <= 1'b0;
        end
    end

    // ********************************
    // interrupt status, mask, output
    // ********************************
    wire [1:0] irq_set = {bad_clr, close_now};
    wire [1:0] irq_clr = {2{w_istat}} & i_wb_dat[1:0];
    wire [1:0] irq_next;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_irq
            assign irq_next[g] = irq_set[g] | (irq_stat_reg[g] & ~irq_clr[g]);
        end
    endgenerate

    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            irq_stat_reg <= 2'h0;
        end else begin
            irq_stat_reg <= irq_next;
        end
    end

    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            irq_mask_reg <= `RBH_MASK_RST;
        end else if (w_imask) begin
            irq_mask_reg <= i_wb_dat[1:0];
        end
    end

    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(irq_stat_reg & irq_mask_reg);
        end
    end

    // ********************************
    // control word
    // ********************************
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ctrl_reg <= `RBH_CTRL_RST;
        end else if (w_ctrl) begin
            ctrl_reg <= i_wb_dat[3:0];
        end
    end

    // ********************************
    // wishbone read and ack
    // ********************************
    wire [3:0] rd_lo_idx = {i_wb_adr[2], i_wb_adr[1:0], 1'b0};
    wire [3:0] rd_hi_idx = {i_wb_adr[2], i_wb_adr[1:0], 1'b1};
    reg [31:0] rd_data;
    always @* begin
        rd_data = 32'h0;
        case (i_wb_adr)
            `RBH_ADR_STAT0: rd_data = {24'h0, stat_reg[0]};
            `RBH_ADR_STAT1: rd_data = {24'h0, stat_reg[1]};
            `RBH_ADR_SYSTEM_ERROR_WORD: rd_data = {31'h0, sys_err_reg};
            `RBH_ADR_IRQ_STAT: rd_data = {30'h0, irq_stat_reg};
            `RBH_ADR_IRQ_MASK: rd_data = {30'h0, irq_mask_reg};
            `RBH_ADR_CTRL: rd_data = {28'h0, ctrl_reg};
            4'h8: rd_data = {16'h0, mem_reg[rd_hi_idx], mem_reg[rd_lo_idx]};
            4'h9: rd_data = {16'h0, mem_reg[rd_hi_idx], mem_reg[rd_lo_idx]};
            4'hA: rd_data = {16'h0, mem_reg[rd_hi_idx], mem_reg[rd_lo_idx]};
            4'hB: rd_data = {16'h0, mem_reg[rd_hi_idx], mem_reg[rd_lo_idx]};
            4'hC: rd_data = {16'h0, mem_reg[rd_hi_idx], mem_reg[rd_lo_idx]};
            4'hD: rd_data = {16'h0, mem_reg[rd_hi_idx], mem_reg[rd_lo_idx]};
            4'hE: rd_data = {16'h0, mem_reg[rd_hi_idx], mem_reg[rd_lo_idx]};
            4'hF: rd_data = {16'h0, mem_reg[rd_hi_idx], mem_reg[rd_lo_idx]};
            default: rd_data = 32'h0;
        endcase
    end

    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_wb_ack <= 1'b0;
        end else begin
            o_wb_ack <= wb_req;
        end
    end

    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_wb_dat <= 32'h0;
        end else begin
            o_wb_dat <= wb_req ? rd_data : 32'h0;
        end
    end

endmodule

// File: bench/rbh_rx_buffer_assertions.sv
// port checker for the receive buffer block
`timescale 1ns/1ps
module rbh_rx_buffer_chk (
    input wire i_clk,
    input wire i_rst_n,
    input wire i_wb_cyc,
    input wire i_wb_stb,
    input wire i_wb_we,
    input wire [31:0] o_wb_dat,
    input wire o_wb_ack,
    input wire i_rx_valid,
    input wire o_rx_ready,
    input wire o_irq
);
// ****
// properties
// ****
default clocking @(posedge i_clk); endclocking
default disable iff (!i_rst_n);
ack_answer_a: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack) else $error("no ack");
ack_pulse_a: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack too long");
ack_cause_a: assert property (o_wb_ack |-> $past(i_wb_cyc && i_wb_stb)) else $error("stray ack");
dat_idle_a: assert property (!o_wb_ack |-> o_wb_dat == 32'h0) else $error("data not zero");
irq_rise_a: assert property ($rose(o_irq) |-> $past(i_rx_valid, 2) ||
    $past(o_wb_ack && i_wb_we)) else $error("irq without cause");
irq_fall_a: assert property ($fell(o_irq) |-> $past(o_wb_ack && i_wb_we))
    else $error("irq dropped without write");
ready_fall_a: assert property ($fell(o_rx_ready) |->
    $past(i_rx_valid) || $past(i_rx_valid, 2)) else $error("ready dropped");
ready_reset_a: assert property ($rose(i_rst_n) |=> o_rx_ready) else $error("not ready");
endmodule
bind rbh_rx_buffer rbh_rx_buffer_chk chk_u (.*);

// File: bench/rbh_deframer_model.sv
// deframer model feeding received bytes
`timescale 1ns/1ps
module rbh_deframer_model (
    input wire i_clk,
    output logic o_valid = 1'b0,
    output logic [7:0] o_byte = 8'h00,
    output logic o_start = 1'b0,
    output logic o_end = 1'b0,
    output logic [1:0] o_err = 2'h0
);
// ****
// byte source
// ****
task send(input int n, input logic [7:0] b, input logic s, input logic e, input logic [1:0] r);
    for (int i = 0; i < n; i++) begin
        o_valid <= 1'b1;
        o_byte <= b + 8'(i);
        o_start <= s && i == 0;
        o_end <= e && i == n - 1;
        o_err <= (i == n - 1) ? r : 2'h0;
        @(posedge i_clk);
    end
    o_valid <= 1'b0;
    o_byte <= ~o_byte;
    o_err <= ~o_err;
endtask
endmodule

// File: bench/tb.sv
// self-checking bench for the receive buffer block
`timescale 1ns/1ps
`include "rbh_map.vh"
module tb;
typedef struct {logic h; int n; logic s; logic e; logic [1:0] r; logic [7:0] x;} rbh_row_t;
logic clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0;
logic [3:0] adr = 4'h0;
logic [31:0] dat = 32'h0, q, odat;
logic ack, rdy, irq, v, st, en;
logic [7:0] by;
logic [1:0] er;
logic rxb = 1'b0;
logic [7:0] fpat = 8'hA5;
int n_errors = 0, checks_done = 0;
rbh_row_t rows [6] = '{'{0, 8, 1, 0, 0, 8'h08}, '{1, 3, 1, 1, 0, 8'hC3}, '{1, 2, 0, 0, 1, 8'h12},
    '{1, 1, 0, 0, 2, 8'h21}, '{1, 8, 1, 0, 0, 8'h48}, '{1, 4, 0, 1, 3, 8'hB4}};
always #2.5 clk = ~clk;
rbh_rx_buffer #(.DIV_1200(8), .DIV_300(8), .DIV_75(8)) dut_u (.i_clk(clk), .i_rst_n(rst_n),
    .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF),
    .i_wb_dat(dat), .o_wb_dat(odat), .o_wb_ack(ack), .i_rx_valid(v), .i_rx_byte(by),
    .i_rx_bit(rxb), .i_rx_frame_start(st), .i_rx_frame_end(en), .i_rx_err(er),
    .o_rx_ready(rdy), .o_irq(irq));
rbh_deframer_model src_u (.i_clk(clk), .o_valid(v), .o_byte(by), .o_start(st), .o_end(en),
    .o_err(er));
// ****
// tasks and sequence
// ****
task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
        n_errors++;
        $display("wrong value %s expected %h seen %h", nm, e, s);
    end
endtask
task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    @(posedge clk);
    while (ack !== 1'b1) begin
        @(posedge clk);
    end
    q = odat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
endtask
task tally_and_finish;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
endtask
initial begin
    #100000;
    n_errors++;
    tally_and_finish;
end
initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    wb(1, `RBH_ADR_IRQ_MASK, 1);
    for (int k = 0; k < 6; k++) begin
        wb(1, `RBH_ADR_CTRL, {31'h0, rows[k].h});
        src_u.send(rows[k].n, 8'h30 + 8'(k), rows[k].s, rows[k].e, rows[k].r);
        repeat (2) @(posedge clk);
        chk("irq", irq, 1);
        wb(0, k[0] ? `RBH_ADR_STAT1 : `RBH_ADR_STAT0, 0);
        chk("status", q, rows[k].x);
        wb(0, k[0] ? `RBH_ADR_DATA1 : `RBH_ADR_DATA0, 0);
        chk("data", q[7:0], 8'h30 + 8'(k));
        wb(1, k[0] ? `RBH_ADR_STAT1 : `RBH_ADR_STAT0, 0);
        wb(1, `RBH_ADR_IRQ_STAT, 1);
        chk("irq clear", irq, 0);
    end
    wb(1, `RBH_ADR_IRQ_MASK, 0);
    src_u.send(8, 8'h50, 0, 0, 0);
    src_u.send(8, 8'h60, 0, 0, 0);
    @(posedge clk);
    chk("masked irq", irq, 0);
    chk("ready", rdy, 0);
    src_u.send(1, 8'h70, 0, 0, 0);
    wb(1, `RBH_ADR_STAT1, 0);
    wb(0, `RBH_ADR_SYSTEM_ERROR_WORD, 0);
    chk("system_error_word", q, 1);
    wb(0, `RBH_ADR_STAT1, 0);
    chk("status1", q, 8'h08);
    wb(1, `RBH_ADR_SYSTEM_ERROR_WORD, 1);
    wb(1, `RBH_ADR_STAT0, 5);
    wb(0, `RBH_ADR_STAT0, 0);
    chk("status0", q, 8'h08);
    wb(0, `RBH_ADR_SYSTEM_ERROR_WORD, 0);
    chk("system_error_word", q, 1);
    wb(1, `RBH_ADR_STAT0, 0);
    wb(1, `RBH_ADR_STAT1, 0);
    chk("ready", rdy, 1);
    wb(1, `RBH_ADR_IRQ_MASK, 3);
    wb(0, `RBH_ADR_IRQ_STAT, 0);
    chk("irq status", q, 3);
    chk("irq", irq, 1);
    wb(0, 4'h6, 0);
    chk("unmapped", q, 0);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk("reset irq", irq, 0);
    chk("reset ready", rdy, 0);
    rst_n <= 1'b1;
    @(posedge clk);
    wb(0, `RBH_ADR_STAT0, 0);
    chk("reset status", q, 0);
    wb(0, `RBH_ADR_IRQ_MASK, 0);
    chk("reset mask", q, 0);
    wb(1, `RBH_ADR_CTRL, 32'h2);
    repeat (2) @(posedge clk);
    for (int j = 0; j < 64; j++) begin
        rxb <= fpat[j[2:0]];
        repeat (8) @(posedge clk);
    end
    wb(0, `RBH_ADR_STAT0, 0);
    chk("fsk status", q, 8'h08);
    wb(0, `RBH_ADR_DATA0, 0);
    chk("fsk data", q[15:0], 16'hA5A5);
    tally_and_finish;
end
endmodule
